//--- hdl/axb_cfg.svh
`ifndef AXB_CFG_SVH
`define AXB_CFG_SVH

// Bus byte address width and register word address width.
`define AXB_ADDR_W 32
`define AXB_WADDR_W 30
// Lowest byte address bit that selects a 32-bit word.
`define AXB_WORD_LSB 2
`define AXB_DATA_W 32
`define AXB_STRB_W 4
// AXI response code OKAY.
`define AXB_RESP_OKAY 2'h0
`define AXB_RESP_W 2

`endif

//--- hdl/axb_pkg.sv
`include "axb_cfg.svh"

package axb_pkg;

   typedef enum logic [1:0] {
      AXB_ST_IDLE = 2'b00,
      AXB_ST_WR = 2'b01,
      AXB_ST_RD_REQ = 2'b10,
      AXB_ST_RD_WAIT = 2'b11
   } axb_state_e;

   // One register-side access: shared word address, write value, lanes.
   typedef struct packed {
      logic [`AXB_WADDR_W-1:0] addr;
      logic [`AXB_DATA_W-1:0] data;
      logic [`AXB_STRB_W-1:0] lanes;
   } axb_access_s;

endpackage : axb_pkg

//--- hdl/axb_bridge.sv
`timescale 1ns/1ps
// Summary of operation
// R1: The block is a standard AXI4-Lite slave on a 32-bit data bus.
// R2: Bus accesses become a simple register interface with 32-bit data.
// R3: Bus and register sides are synchronised so the user clock is free.
// R4: Write control, write data, read control and read data are separate.
// R5: Write address and data are latched and crossed before the write.
// R6: Read address becomes a read request and data returns crossed.
// R7: One word address output serves writes and reads alike.
// R8: A register write and a register read are never issued together.
// R9: A write drives the strobe high with address, value and byte lanes.
// R10: The register address counts 32-bit words, not bytes.
// R11: Four byte lane enables qualify bytes [7:0] up to [31:24].
// R12: A read raises the read request together with a valid address.
// R13: The address holds still until the slave returns read valid.
// R14: The slave starts on the request and answers with valid and data.
// R15: Returned data is captured and sent on the AXI read data channel.
// R16: The reference slave answers two user-clock cycles after a request.
// R17: Every write and read answers OKAY; B follows the register write.
`include "axb_cfg.svh"

module axb_bridge
   import axb_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [`AXB_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [`AXB_DATA_W-1:0] s_axi_wdata,
   input wire logic [`AXB_STRB_W-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [`AXB_RESP_W-1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`AXB_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [`AXB_DATA_W-1:0] s_axi_rdata,
   output logic [`AXB_RESP_W-1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic user_logic_clock,
   output logic reg_write_strobe,
   output logic [`AXB_WADDR_W-1:0] reg_word_address,
   output logic [`AXB_DATA_W-1:0] reg_write_value,
   output logic [`AXB_STRB_W-1:0] reg_byte_lane_enable,
   output logic reg_read_request,
   input wire logic reg_read_return_valid,
   input wire logic [`AXB_DATA_W-1:0] reg_read_value
);

   // User clock is sampled by clk_sys through three stages, read return through two.
   logic uclk_s1_reg, uclk_s2_reg, uclk_s3_reg;
   logic rv_s1_reg, rv_s2_reg;
   logic [`AXB_DATA_W-1:0] rd_s1_reg, rd_s2_reg;
   logic user_edge;

   always_ff @(posedge clk_sys) begin // [R3]
      // The clock stages run through reset, so the edge detector starts at
      // the pin's level and no false edge follows the release.
      uclk_s1_reg <= user_logic_clock;
      uclk_s2_reg <= uclk_s1_reg;
      uclk_s3_reg <= uclk_s2_reg;
      if (reset) begin
         rv_s1_reg <= 1'b0;
         rv_s2_reg <= 1'b0;
         rd_s1_reg <= '0;
         rd_s2_reg <= '0;
      end else begin
         rv_s1_reg <= reg_read_return_valid;
         rv_s2_reg <= rv_s1_reg;
         rd_s1_reg <= reg_read_value;
         rd_s2_reg <= rd_s1_reg;
      end
   end

   // Outputs change a few system cycles after a user rising edge, so the
   // slave sees them stable for nearly a whole user period; slave outputs
   // have likewise settled by the time they are looked at here.
   assign user_edge = uclk_s2_reg & ~uclk_s3_reg; // [R3]

   axb_state_e state_reg, state_next;
   logic [`AXB_WADDR_W-1:0] aw_addr_reg, aw_addr_next;
   logic aw_full_reg, aw_full_next;
   logic [`AXB_DATA_W-1:0] w_data_reg, w_data_next;
   logic [`AXB_STRB_W-1:0] w_lanes_reg, w_lanes_next;
   logic w_full_reg, w_full_next;
   logic [`AXB_WADDR_W-1:0] ar_addr_reg, ar_addr_next;
   logic ar_full_reg, ar_full_next;
   logic awready_reg, awready_next;
   logic wready_reg, wready_next;
   logic arready_reg, arready_next;
   logic bvalid_reg, bvalid_next;
   logic rvalid_reg, rvalid_next;
   logic [`AXB_DATA_W-1:0] rdata_reg, rdata_next;
   logic [`AXB_RESP_W-1:0] resp_reg, resp_next;
   axb_access_s access_reg, access_next;
   logic strobe_reg, strobe_next;
   logic rdreq_reg, rdreq_next;

   always_comb begin
      state_next = state_reg;
      aw_addr_next = aw_addr_reg;
      aw_full_next = aw_full_reg;
      w_data_next = w_data_reg;
      w_lanes_next = w_lanes_reg;
      w_full_next = w_full_reg;
      ar_addr_next = ar_addr_reg;
      ar_full_next = ar_full_reg;
      bvalid_next = bvalid_reg;
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      resp_next = `AXB_RESP_OKAY; // [R17]
      access_next = access_reg;
      strobe_next = strobe_reg;
      rdreq_next = rdreq_reg;

      // Write control, write data and read control latch independently.
      if (s_axi_awvalid && awready_reg) begin // [R4] [R5] [R10]
         aw_addr_next = s_axi_awaddr[`AXB_ADDR_W-1:`AXB_WORD_LSB];
         aw_full_next = 1'b1;
      end
      if (s_axi_wvalid && wready_reg) begin // [R4] [R5]
         w_data_next = s_axi_wdata;
         w_lanes_next = s_axi_wstrb;
         w_full_next = 1'b1;
      end
      if (s_axi_arvalid && arready_reg) begin // [R4] [R6] [R10]
         ar_addr_next = s_axi_araddr[`AXB_ADDR_W-1:`AXB_WORD_LSB];
         ar_full_next = 1'b1;
      end
      if (bvalid_reg && s_axi_bready) begin // [R1]
         bvalid_next = 1'b0;
      end
      if (rvalid_reg && s_axi_rready) begin // [R1]
         rvalid_next = 1'b0;
      end

      // One access at a time on the shared address; writes go first when
      // both are waiting, which can delay reads under a stream of writes.
      case (state_reg)
         AXB_ST_IDLE: begin
            if (user_edge) begin
               if (aw_full_reg && w_full_reg && !bvalid_reg) begin // [R8]
                  access_next.addr = aw_addr_reg; // [R7]
                  access_next.data = w_data_reg; // [R2]
                  access_next.lanes = w_lanes_reg; // [R11]
                  strobe_next = 1'b1; // [R9]
                  state_next = AXB_ST_WR;
               end else if (ar_full_reg && !rvalid_reg) begin // [R8]
                  access_next.addr = ar_addr_reg; // [R7]
                  rdreq_next = 1'b1; // [R12]
                  state_next = AXB_ST_RD_REQ;
               end
            end
         end
         AXB_ST_WR: begin
            if (user_edge) begin
               strobe_next = 1'b0; // [R9]
               aw_full_next = 1'b0;
               w_full_next = 1'b0;
               bvalid_next = 1'b1; // [R17]
               state_next = AXB_ST_IDLE;
            end
         end
         AXB_ST_RD_REQ, AXB_ST_RD_WAIT: begin
            if (user_edge) begin
               rdreq_next = 1'b0; // [R12]
               state_next = AXB_ST_RD_WAIT;
               // Address stays put until valid comes back. [R13] [R14]
               if (rv_s2_reg && state_reg == AXB_ST_RD_WAIT) begin // [R16]
                  rdata_next = rd_s2_reg; // [R6] [R15]
                  rvalid_next = 1'b1; // [R15]
                  ar_full_next = 1'b0;
                  state_next = AXB_ST_IDLE;
               end
            end
         end
         default: begin
            state_next = AXB_ST_IDLE;
            strobe_next = 1'b0;
            rdreq_next = 1'b0;
         end
      endcase

      awready_next = !aw_full_next; // [R1]
      wready_next = !w_full_next; // [R1]
      arready_next = !ar_full_next; // [R1]
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_reg <= AXB_ST_IDLE;
         aw_addr_reg <= '0;
         aw_full_reg <= 1'b0;
         w_data_reg <= '0;
         w_lanes_reg <= '0;
         w_full_reg <= 1'b0;
         ar_addr_reg <= '0;
         ar_full_reg <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         arready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         resp_reg <= `AXB_RESP_OKAY;
         access_reg <= '0;
         strobe_reg <= 1'b0;
         rdreq_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         aw_addr_reg <= aw_addr_next;
         aw_full_reg <= aw_full_next;
         w_data_reg <= w_data_next;
         w_lanes_reg <= w_lanes_next;
         w_full_reg <= w_full_next;
         ar_addr_reg <= ar_addr_next;
         ar_full_reg <= ar_full_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         arready_reg <= arready_next;
         bvalid_reg <= bvalid_next;
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         resp_reg <= resp_next;
         access_reg <= access_next;
         strobe_reg <= strobe_next;
         rdreq_reg <= rdreq_next;
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = resp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = resp_reg;
   assign s_axi_rdata = rdata_reg;
   assign reg_write_strobe = strobe_reg;
   assign reg_word_address = access_reg.addr;
   assign reg_write_value = access_reg.data;
   assign reg_byte_lane_enable = access_reg.lanes;
   assign reg_read_request = rdreq_reg;

endmodule : axb_bridge

//--- dv/axb_bridge_sva.sv
`timescale 1ns/1ps
`include "axb_cfg.svh"
module axb_bridge_sva
   import axb_pkg::*;
(
   input logic clk_sys,
   input logic reset,
   input logic [31:0] s_axi_awaddr,
   input logic s_axi_awvalid,
   input logic s_axi_awready,
   input logic [31:0] s_axi_wdata,
   input logic [3:0] s_axi_wstrb,
   input logic s_axi_wvalid,
   input logic s_axi_wready,
   input logic [1:0] s_axi_bresp,
   input logic s_axi_bvalid,
   input logic [31:0] s_axi_araddr,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic [1:0] s_axi_rresp,
   input logic s_axi_rvalid,
   input logic reg_write_strobe,
   input logic [29:0] reg_word_address,
   input logic [31:0] reg_write_value,
   input logic [3:0] reg_byte_lane_enable,
   input logic reg_read_request,
   input logic reg_read_return_valid,
   input logic [31:0] reg_read_value
);
   logic [31:0] aw_q, wd_q, ar_q, rv_q;
   logic [3:0] ws_q;
   logic rd_busy;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   always_ff @(posedge clk_sys) begin
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata;
      if (s_axi_wvalid && s_axi_wready) ws_q <= s_axi_wstrb;
      if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
      if (reg_read_return_valid) rv_q <= reg_read_value;
      // Busy from the cycle after the request rises until rvalid is seen.
      if (reset || s_axi_rvalid) rd_busy <= 1'b0;
      else if (reg_read_request) rd_busy <= 1'b1;
   end
   sequence s_rd_start;
      $rose(reg_read_request);
   endsequence
   sequence s_wr_start;
      $rose(reg_write_strobe);
   endsequence
   a_no_overlap: assert property (
      !(reg_write_strobe && reg_read_request))
      else $error("write strobe and read request together");
   a_wr_addr: assert property (
      s_wr_start |-> reg_word_address == aw_q[31:2])
      else $error("write word address wrong");
   a_wr_data: assert property (
      s_wr_start |-> reg_write_value == wd_q
      && reg_byte_lane_enable == ws_q)
      else $error("write value or lanes wrong");
   a_wr_issue: assert property (
      s_axi_awvalid && s_axi_awready |-> ##[1:200] reg_write_strobe)
      else $error("write never issued");
   a_strobe_width: assert property (
      s_wr_start |=> reg_write_strobe [*6])
      else $error("write strobe too short");
   a_rd_addr: assert property (
      s_rd_start |-> reg_word_address == ar_q[31:2])
      else $error("read word address wrong");
   a_rd_hold: assert property (
      rd_busy |-> $stable(reg_word_address))
      else $error("address moved during a read");
   a_rd_bound: assert property (
      s_rd_start |-> ##[1:200] s_axi_rvalid)
      else $error("read never answered");
   a_rd_data: assert property (
      $rose(s_axi_rvalid) |-> s_axi_rdata == rv_q
      && s_axi_rresp == `AXB_RESP_OKAY)
      else $error("read data wrong");
   a_b_after_wr: assert property (
      $rose(s_axi_bvalid) |-> $fell(reg_write_strobe)
      && s_axi_bresp == `AXB_RESP_OKAY)
      else $error("write response out of place");
endmodule : axb_bridge_sva
bind axb_bridge axb_bridge_sva u_axb_bridge_sva (.*);

//--- dv/axb_slave_model.sv
`timescale 1ns/1ps
module axb_slave_model
   import axb_pkg::*;
(
   input logic user_logic_clock,
   input logic reg_write_strobe,
   input logic [29:0] reg_word_address,
   input logic [31:0] reg_write_value,
   input logic [3:0] reg_byte_lane_enable,
   input logic reg_read_request,
   output logic reg_read_return_valid,
   output logic [31:0] reg_read_value
);
   logic [31:0] mem [0:15];
   logic [1:0] dly = 2'h0;
   logic [31:0] rd_q = 32'h0;
   initial foreach (mem[i]) mem[i] = 32'h0;
   // Only four word bits decode, so higher addresses alias onto this file.
   always @(posedge user_logic_clock) begin
      if (reg_write_strobe)
         for (int i = 0; i < 4; i++)
            if (reg_byte_lane_enable[i])
               mem[reg_word_address[3:0]][8*i +: 8] <=
                  reg_write_value[8*i +: 8];
      dly <= {dly[0], reg_read_request};
      if (dly[0]) rd_q <= mem[reg_word_address[3:0]];
   end
   assign reg_read_return_valid = dly[1];
   // Outside valid the data bus shows garbage so stale captures are caught.
   assign reg_read_value = dly[1] ? rd_q : ~rd_q;
endmodule : axb_slave_model

//--- dv/axb_bridge_tb.sv
`timescale 1ns/1ps
module axb_bridge_tb
   import axb_pkg::*;
;
   logic clk_sys = 1'b0, reset = 1'b1, user_logic_clock = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
   logic [31:0] s_axi_araddr = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic reg_write_strobe, reg_read_request, reg_read_return_valid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, reg_write_value, reg_read_value;
   logic [29:0] reg_word_address;
   logic [3:0] reg_byte_lane_enable;
   int num_errors = 0, tests_run = 0;
   axb_bridge u_axb_bridge (.*);
   axb_slave_model u_axb_slave_model (.*);
   always #50 clk_sys = ~clk_sys;
   initial begin
      #137;
      forever #400 user_logic_clock = ~user_logic_clock;
   end
   task automatic check(input string what, input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic axi_write(input logic [31:0] a, d, input logic [3:0] s,
      input int stall);
      @(negedge clk_sys iff (s_axi_awready & s_axi_wready) === 1'b1);
      s_axi_awaddr = a;
      s_axi_wdata = d;
      s_axi_wstrb = s;
      s_axi_awvalid = 1'b1;
      s_axi_wvalid = 1'b1;
      @(negedge clk_sys);
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      @(negedge clk_sys iff s_axi_bvalid === 1'b1);
      repeat (stall) @(negedge clk_sys);
      check("bvalid", {31'h0, s_axi_bvalid}, 32'h1);
      check("bresp", {30'h0, s_axi_bresp}, 32'h0);
      s_axi_bready = 1'b1;
      @(negedge clk_sys);
      s_axi_bready = 1'b0;
   endtask : axi_write
   task automatic axi_read(input logic [31:0] a, input int stall,
      output logic [31:0] d);
      @(negedge clk_sys iff s_axi_arready === 1'b1);
      s_axi_araddr = a;
      s_axi_arvalid = 1'b1;
      @(negedge clk_sys);
      s_axi_arvalid = 1'b0;
      @(negedge clk_sys iff s_axi_rvalid === 1'b1);
      d = s_axi_rdata;
      repeat (stall) @(negedge clk_sys);
      check("rdata held", s_axi_rdata, d);
      check("rresp", {30'h0, s_axi_rresp}, 32'h0);
      s_axi_rready = 1'b1;
      @(negedge clk_sys);
      s_axi_rready = 1'b0;
   endtask : axi_read
   task automatic test_reset;
      logic [31:0] rdy;
      repeat (12) @(negedge clk_sys);
      reset = 1'b0;
      repeat (2) @(negedge clk_sys);
      rdy = {29'h0, s_axi_awready, s_axi_wready, s_axi_arready};
      check("ready", rdy, 32'h7);
      $display("test_reset done");
   endtask : test_reset
   task automatic test_lanes;
      logic [31:0] d, e;
      e = 32'h0;
      for (int i = 0; i < 4; i++) begin
         axi_write(32'h14, 32'hFFFFFFFF, 4'(1 << i), i);
         e = e | (32'hFF << (8 * i));
         axi_read(32'h14, 3 - i, d);
         check("lane merge", d, e);
      end
      $display("test_lanes done");
   endtask : test_lanes
   task automatic test_addr_map;
      logic [31:0] d, m;
      for (int i = 0; i < 4; i++)
         axi_write(32'(32'h20 + 5 * i), 32'(32'hA0 + i), 4'hF, 0);
      for (int i = 0; i < 4; i++) begin
         m = u_axb_slave_model.mem[8 + i];
         check("word store", m, 32'(32'hA0 + i));
         axi_read(32'(32'h20 + 4 * i + 3 - i), 0, d);
         check("word read", d, 32'(32'hA0 + i));
      end
      $display("test_addr_map done");
   endtask : test_addr_map
   task automatic test_overlap;
      logic [31:0] d;
      fork
         axi_write(32'h30, 32'h5A5A0F0F, 4'hF, 2);
         axi_read(32'h24, 1, d);
      join
      check("read beside write", d, 32'hA1);
      axi_read(32'h30, 0, d);
      check("write beside read", d, 32'h5A5A0F0F);
      $display("test_overlap done");
   endtask : test_overlap
   task automatic finish_test;
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test
   initial begin
      test_reset();
      test_lanes();
      test_addr_map();
      test_overlap();
      finish_test();
   end
   initial begin
      #2000000;
      num_errors++;
      finish_test();
   end
endmodule : axb_bridge_tb
